// ---- hdl/uaar_top.sv ----
// Serial port control, address recognition and AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module uaar_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [uaar_pkg::ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Receive framing sequencer
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_ninth_bit_i,
  input wire logic rx_ninth_strobe_i,
  input wire logic rx_stop_bit_i,
  input wire logic rx_stop_strobe_i,
  output logic rx_enable_o,
  // Transmit framing sequencer
  input wire logic tx_done_i,
  output logic tx_start_o,
  output logic [7:0] tx_data_o,
  output logic tx_ninth_bit_o,
  output logic [1:0] serial_mode_o,
  // Toward the core
  output logic serial_request_o,
  output logic serial_irq_o
);
  import uaar_pkg::*;

  // Bus pipeline
  logic wr_phase_reg;
  logic rd_phase_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic addr_ok;
  logic [7:0] rd_mux;

  // Register state
  logic serial_mode_bit0_reg;
  logic serial_mode_bit1_reg;
  logic multiproc_enable_reg;
  logic rx_enable_reg;
  logic tx_ninth_bit_reg;
  logic rx_ninth_bit_reg;
  logic tx_done_flag_reg;
  logic rx_done_flag_reg;
  logic framing_error_flag_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] tx_buffer_reg;
  logic tx_start_reg;
  logic [7:0] slave_individual_address_reg;
  logic [7:0] slave_address_mask_reg;
  logic frame_check_select_reg;
  logic serial_irq_enable_reg;
  logic global_irq_enable_reg;

  // Receive decision
  logic [1:0] mode;
  logic wr_control;
  logic wr_buffer;
  logic rx_event;
  logic mark_bit;
  logic mp_active;
  logic given_match;
  logic [7:0] broadcast_addr;
  logic bcast_match;
  logic rx_accept;
  logic fe_set;

  // Reads get one wait state so a write just before is always visible
  assign addr_ok = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;
  assign hreadyout_o = !rd_phase_reg;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_phase_reg <= 1'b0;
      rd_phase_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      wr_phase_reg <= addr_ok && hwrite_i;
      rd_phase_reg <= addr_ok && !hwrite_i;
      if (addr_ok) begin
        addr_reg <= haddr_i;
      end
    end
  end

  always_comb begin
    case (addr_reg)
      ADDR_SERIAL_CONTROL: begin
        rd_mux = {frame_check_select_reg ? framing_error_flag_reg : serial_mode_bit0_reg,
                  serial_mode_bit1_reg, multiproc_enable_reg, rx_enable_reg,
                  tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
      end
      ADDR_SERIAL_BUFFER: rd_mux = rx_buffer_reg;
      ADDR_SLAVE_ADDR: rd_mux = slave_individual_address_reg;
      ADDR_SLAVE_MASK: rd_mux = slave_address_mask_reg;
      ADDR_MISC_CONTROL: begin
        rd_mux = {5'h00, global_irq_enable_reg, serial_irq_enable_reg, frame_check_select_reg};
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_phase_reg) begin
      hrdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  assign wr_control = wr_phase_reg && (addr_reg == ADDR_SERIAL_CONTROL);
  assign wr_buffer = wr_phase_reg && (addr_reg == ADDR_SERIAL_BUFFER);
  assign mode = {serial_mode_bit0_reg, serial_mode_bit1_reg};

  // Mode and control bits; bit 7 writes go to the error flag under frame check
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_mode_bit0_reg <= 1'b0;
      serial_mode_bit1_reg <= 1'b0;
      multiproc_enable_reg <= 1'b0;
      rx_enable_reg <= 1'b0;
      tx_ninth_bit_reg <= 1'b0;
    end else if (wr_control) begin
      if (!frame_check_select_reg) begin
        serial_mode_bit0_reg <= hwdata_i[BIT_MODE0_FE];
      end
      serial_mode_bit1_reg <= hwdata_i[BIT_MODE1];
      multiproc_enable_reg <= hwdata_i[BIT_MULTIPROC];
      rx_enable_reg <= hwdata_i[BIT_RX_ENABLE];
      tx_ninth_bit_reg <= hwdata_i[BIT_TX_NINTH];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slave_individual_address_reg <= RST_BYTE;
      slave_address_mask_reg <= RST_BYTE;
      frame_check_select_reg <= 1'b0;
      serial_irq_enable_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
    end else if (wr_phase_reg) begin
      if (addr_reg == ADDR_SLAVE_ADDR) begin
        slave_individual_address_reg <= hwdata_i[7:0];
      end
      if (addr_reg == ADDR_SLAVE_MASK) begin
        slave_address_mask_reg <= hwdata_i[7:0];
      end
      if (addr_reg == ADDR_MISC_CONTROL) begin
        frame_check_select_reg <= hwdata_i[BIT_FRAME_CHECK];
        serial_irq_enable_reg <= hwdata_i[BIT_SERIAL_IRQ_EN];
        global_irq_enable_reg <= hwdata_i[BIT_GLOBAL_IRQ_EN];
      end
    end
  end

  // Frame completes at the stop bit in modes 0 and 1 and under frame check,
  // otherwise already at the ninth bit
  assign rx_event = rx_enable_reg &&
                    (((mode[1] == 1'b0) || frame_check_select_reg) ? rx_stop_strobe_i
                                                                   : rx_ninth_strobe_i);
  assign mark_bit = (mode == MODE_UART8) ? rx_stop_bit_i : rx_ninth_bit_i;
  assign mp_active = multiproc_enable_reg && (mode != MODE_SHIFT);
  assign given_match = ((rx_byte_i ^ slave_individual_address_reg)
                        & slave_address_mask_reg) == 8'h00;
  assign broadcast_addr = slave_individual_address_reg | slave_address_mask_reg;
  assign bcast_match = (rx_byte_i & broadcast_addr) == broadcast_addr;
  assign rx_accept = rx_event &&
                     (!mp_active || (mark_bit && (given_match || bcast_match)));
  assign fe_set = rx_enable_reg && frame_check_select_reg && rx_stop_strobe_i &&
                  !rx_stop_bit_i && (mode != MODE_SHIFT);

  // Hardware only sets the done flags; a set in the cycle of a clear wins
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_done_flag_reg <= 1'b0;
      tx_done_flag_reg <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_done_flag_reg <= 1'b1;
      end else if (wr_control) begin
        rx_done_flag_reg <= hwdata_i[BIT_RX_DONE];
      end
      if (tx_done_i) begin
        tx_done_flag_reg <= 1'b1;
      end else if (wr_control) begin
        tx_done_flag_reg <= hwdata_i[BIT_TX_DONE];
      end
    end
  end

  // Later good frames never clear the error flag; only software does
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      framing_error_flag_reg <= 1'b0;
    end else if (fe_set) begin
      framing_error_flag_reg <= 1'b1;
    end else if (wr_control && frame_check_select_reg) begin
      framing_error_flag_reg <= hwdata_i[BIT_MODE0_FE];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_buffer_reg <= RST_BYTE;
      rx_ninth_bit_reg <= 1'b0;
    end else if (rx_accept) begin
      rx_buffer_reg <= rx_byte_i;
      if (mode != MODE_SHIFT) begin
        rx_ninth_bit_reg <= mark_bit;
      end
    end else if (wr_control) begin
      rx_ninth_bit_reg <= hwdata_i[BIT_RX_NINTH];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_buffer_reg <= RST_BYTE;
      tx_start_reg <= 1'b0;
    end else begin
      tx_start_reg <= wr_buffer && (mode != MODE_SHIFT);
      if (wr_buffer) begin
        tx_buffer_reg <= hwdata_i[7:0];
      end
    end
  end

  assign tx_start_o = tx_start_reg;
  assign tx_data_o = tx_buffer_reg;
  assign tx_ninth_bit_o = tx_ninth_bit_reg && mode[1];
  assign serial_mode_o = mode;
  assign rx_enable_o = rx_enable_reg;
  assign serial_request_o = rx_done_flag_reg || tx_done_flag_reg;
  assign serial_irq_o = serial_request_o && serial_irq_enable_reg &&
                        global_irq_enable_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_irq_gate;
    !(serial_irq_enable_reg && global_irq_enable_reg) |-> !serial_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without both enables");

  property p_irq_or;
    tx_done_i && serial_irq_enable_reg && global_irq_enable_reg && !wr_phase_reg
      |=> serial_request_o && serial_irq_o;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("tx done did not raise irq");

  property p_tx_done;
    tx_done_i |=> tx_done_flag_reg;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done flag not set");

  property p_mode0_no_filter;
    rx_enable_reg && mode == MODE_SHIFT && rx_stop_strobe_i |=> rx_done_flag_reg;
  endproperty
  a_mode0_no_filter: assert property (p_mode0_no_filter)
    else $error("mode 0 frame filtered");

  property p_ninth_zero_drop;
    !rx_done_flag_reg && !wr_control && rx_enable_reg && multiproc_enable_reg && mode[1] &&
      !frame_check_select_reg && rx_ninth_strobe_i && !rx_ninth_bit_i |=> !rx_done_flag_reg;
  endproperty
  a_ninth_zero_drop: assert property (p_ninth_zero_drop)
    else $error("data frame not discarded");

  property p_given_match;
    rx_enable_reg && multiproc_enable_reg && mode == MODE_UART8 && rx_stop_strobe_i &&
      rx_stop_bit_i && ((rx_byte_i ^ slave_individual_address_reg)
      & slave_address_mask_reg) == 8'h00 |=> rx_done_flag_reg && rx_buffer_reg == $past(rx_byte_i);
  endproperty
  a_given_match: assert property (p_given_match) else $error("matching address lost");

  property p_no_match;
    !rx_done_flag_reg && !wr_control && rx_event && mp_active && !given_match && !bcast_match
      |=> !rx_done_flag_reg;
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign address accepted");

  property p_rx_blocked;
    !rx_enable_reg && !rx_done_flag_reg && !wr_control |=> !rx_done_flag_reg;
  endproperty
  a_rx_blocked: assert property (p_rx_blocked) else $error("rx while disabled");

  property p_framing;
    fe_set |=> framing_error_flag_reg ##1 (framing_error_flag_reg || $past(wr_control));
  endproperty
  a_framing: assert property (p_framing) else $error("framing error not held");

  property p_tx_start;
    wr_buffer && mode != MODE_SHIFT |=> tx_start_o && tx_data_o == $past(hwdata_i[7:0])
      ##1 (!tx_start_o || $past(wr_buffer));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start pulse wrong");

  property p_rb8_mode1;
    rx_accept && mode == MODE_UART8 |=> rx_ninth_bit_reg == $past(rx_stop_bit_i);
  endproperty
  a_rb8_mode1: assert property (p_rb8_mode1) else $error("stop bit not captured");

  property p_reset_addr;
    !$past(rst_n_i) |-> slave_individual_address_reg == 8'h00 && slave_address_mask_reg == 8'h00;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("address not cleared");

  property p_tx_ninth;
    tx_ninth_bit_o |-> mode[1] && tx_ninth_bit_reg;
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("ninth bit in 8-bit mode");

  property p_tx_ninth_sent;
    mode[1] && tx_ninth_bit_reg |-> tx_ninth_bit_o;
  endproperty
  a_tx_ninth_sent: assert property (p_tx_ninth_sent) else $error("ninth bit not sent");

  // Broadcast check written out again so a fault in bcast_match is still caught
  property p_bcast_accept;
    rx_event && mp_active && mark_bit && ((rx_byte_i & (slave_individual_address_reg |
      slave_address_mask_reg)) == (slave_individual_address_reg | slave_address_mask_reg))
      |=> rx_done_flag_reg && rx_buffer_reg == $past(rx_byte_i);
  endproperty
  a_bcast_accept: assert property (p_bcast_accept) else $error("broadcast lost");

  property p_ninth_event;
    rx_enable_reg && mode[1] && !multiproc_enable_reg && !frame_check_select_reg &&
      rx_ninth_strobe_i |=> rx_done_flag_reg;
  endproperty
  a_ninth_event: assert property (p_ninth_event) else $error("ninth bit frame lost");

  property p_shift_no_tx;
    wr_buffer && mode == MODE_SHIFT |=> !tx_start_o;
  endproperty
  a_shift_no_tx: assert property (p_shift_no_tx) else $error("mode 0 started a frame");

  c_given: cover property (rx_accept && mp_active && given_match);
  c_bcast: cover property (rx_accept && mp_active && bcast_match && !given_match);
  c_frame_err: cover property (fe_set);
  c_tx: cover property (tx_start_o ##[1:50] tx_done_i);

endmodule : uaar_top
`default_nettype wire

// ---- hdl/uaar_pkg.sv ----
// Constants for the serial port address recognition and control block
`default_nettype none
package uaar_pkg;
  localparam int ADDR_W = 12;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_SLAVE_ADDR = 8'ha9;
  localparam logic [7:0] IDX_SLAVE_MASK = 8'hb9;
  localparam logic [7:0] IDX_MISC_CONTROL = 8'hc0;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_CONTROL = {2'h0, IDX_SERIAL_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_BUFFER = {2'h0, IDX_SERIAL_BUFFER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SLAVE_ADDR = {2'h0, IDX_SLAVE_ADDR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SLAVE_MASK = {2'h0, IDX_SLAVE_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MISC_CONTROL = {2'h0, IDX_MISC_CONTROL, 2'h0};
  // serial_control bit positions
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_MODE1 = 6;
  localparam int BIT_MODE0_FE = 7;
  // misc_control bit positions
  localparam int BIT_FRAME_CHECK = 0;
  localparam int BIT_SERIAL_IRQ_EN = 1;
  localparam int BIT_GLOBAL_IRQ_EN = 2;
  // Reset value, serial mode encodings and AHB transfer type
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : uaar_pkg
`default_nettype wire

// ---- verif/uaar_far_model.sv ----
// Far-side model: remote master frames arriving and a transmit line that finishes frames
`timescale 1ns/1ns
`default_nettype none
module uaar_far_model (
  input wire logic clock_i,
  input wire logic tx_start_i,
  input wire logic [3:0] tx_delay_i,
  output logic [7:0] rx_byte_o,
  output logic rx_ninth_bit_o,
  output logic rx_ninth_strobe_o,
  output logic rx_stop_bit_o,
  output logic rx_stop_strobe_o,
  output logic tx_done_o
);
  int wait_cnt = -1;

  initial begin
    rx_byte_o = 8'h00;
    rx_ninth_bit_o = 1'b0;
    rx_ninth_strobe_o = 1'b0;
    rx_stop_bit_o = 1'b1;
    rx_stop_strobe_o = 1'b0;
    tx_done_o = 1'b0;
  end

  // A frame: ninth bit sample (9-bit modes), then stop bit sample
  task automatic send_frame(input logic [7:0] b, input logic nb, input logic sb,
                            input logic nine);
    @(posedge clock_i);
    rx_byte_o <= b;
    rx_ninth_bit_o <= nb;
    rx_stop_bit_o <= sb;
    rx_ninth_strobe_o <= nine;
    rx_stop_strobe_o <= !nine;
    if (nine) begin
      @(posedge clock_i);
      rx_ninth_strobe_o <= 1'b0;
      rx_stop_strobe_o <= 1'b1;
    end
    @(posedge clock_i);
    rx_stop_strobe_o <= 1'b0;
    // Outside a frame the lines carry nothing useful, so show the inverse
    rx_byte_o <= ~b;
    rx_ninth_bit_o <= ~nb;
    rx_stop_bit_o <= ~sb;
  endtask : send_frame

  // Line finishes the frame after a prompt or slow delay
  always @(posedge clock_i) begin
    tx_done_o <= (wait_cnt == 0);
    if (tx_start_i === 1'b1) begin
      wait_cnt <= int'(tx_delay_i);
    end else if (wait_cnt >= 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : uaar_far_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the serial port control and address recognition block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import uaar_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, rdy_s = 1'b1;
  logic [11:0] haddr = '0, ad;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = '0, hrdata, rd_s = '0, q;
  logic hreadyout, hresp, rx_en, tx_start, tx_ninth, req, irq;
  logic [7:0] rx_byte, tx_data, a, k, r, ctl, last;
  logic rx_nb, rx_ns, rx_sb, rx_ss, tx_done, mp, mk, ren, ok;
  logic [1:0] mode, m;
  logic [3:0] tx_delay = 4'h0;
  int seed, n_fail = 0, n_tests = 0, cyc = 0, n_start = 0, s0;

  uaar_top DUT (.clock_i(clock_i), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .rx_byte_i(rx_byte), .rx_ninth_bit_i(rx_nb), .rx_ninth_strobe_i(rx_ns),
    .rx_stop_bit_i(rx_sb), .rx_stop_strobe_i(rx_ss), .rx_enable_o(rx_en),
    .tx_done_i(tx_done), .tx_start_o(tx_start), .tx_data_o(tx_data),
    .tx_ninth_bit_o(tx_ninth), .serial_mode_o(mode), .serial_request_o(req),
    .serial_irq_o(irq));
  uaar_far_model FAR (.clock_i(clock_i), .tx_start_i(tx_start), .tx_delay_i(tx_delay),
    .rx_byte_o(rx_byte), .rx_ninth_bit_o(rx_nb), .rx_ninth_strobe_o(rx_ns),
    .rx_stop_bit_o(rx_sb), .rx_stop_strobe_o(rx_ss), .tx_done_o(tx_done));

  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // Values seen by the master at the next rising edge
  always @(negedge clock_i) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (tx_start === 1'b1) n_start++;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] ad, input logic [7:0] d);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= ad;
    hwrite <= wr;
    do @(posedge clock_i); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock_i); while (rdy_s !== 1'b1);
    q = rd_s;
  endtask : bus

  function automatic logic accept(input logic [1:0] md, input logic en, input logic mkr,
                                  input logic [7:0] rv, input logic [7:0] av,
                                  input logic [7:0] kv);
    if (!en || md == MODE_SHIFT) return 1'b1;
    return mkr && ((((rv ^ av) & kv) == 8'h00) || ((rv & (av | kv)) == (av | kv)));
  endfunction : accept

  initial begin
    seed = 1780;
    last = 8'h00;
    repeat (8) @(posedge clock_i);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: ad = ADDR_SERIAL_CONTROL;
        1: ad = ADDR_SERIAL_BUFFER;
        2: ad = ADDR_SLAVE_ADDR;
        3: ad = ADDR_SLAVE_MASK;
        4: ad = ADDR_MISC_CONTROL;
        default: ad = 12'h004;
      endcase
      bus(1'b0, ad, 8'h00);
      chk("reset read", q, 32'h0);
    end
    bus(1'b1, 12'h004, 8'h5a);
    bus(1'b0, 12'h004, 8'h00);
    chk("unmapped", q, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    for (int i = 0; i < 48; i++) begin
      m = 2'($random(seed));
      mp = 1'($random(seed));
      mk = 1'($random(seed));
      ren = (i % 8 != 7);
      r = 8'($random(seed));
      a = 8'($random(seed));
      k = 8'($random(seed));
      // Exact hit, exact miss, a mode 1 hit and a broadcast-only hit
      if (i < 4) begin
        {m, mp, mk} = {(i == 2) ? 2'h1 : 2'h3, 2'h3};
        {r, a, k} = (i == 3) ? 24'hfb_f1_fa : {8'h5a, (i == 1) ? 8'h5b : 8'h5a, 8'hff};
      end
      bus(1'b1, ADDR_SLAVE_ADDR, a);
      bus(1'b1, ADDR_SLAVE_MASK, k);
      bus(1'b0, ADDR_SLAVE_MASK, 8'h00);
      chk("mask", q, {24'h0, k});
      ctl = {m, mp, ren, 4'h0};
      bus(1'b1, ADDR_SERIAL_CONTROL, ctl);
      FAR.send_frame(r, mk, (m == 2'h1) ? mk : 1'b1, m[1]);
      ok = ren && accept(m, mp, mk, r, a, k);
      @(negedge clock_i);
      chk("request", 32'(req), 32'(ok));
      chk("rx enable", 32'(rx_en), 32'(ren));
      bus(1'b0, ADDR_SERIAL_CONTROL, 8'h00);
      chk("control", q, {24'h0, ctl | (ok ? {5'h0, (m != 2'h0) && mk, 2'h1} : 8'h00)});
      if (ok) last = r;
      bus(1'b0, ADDR_SERIAL_BUFFER, 8'h00);
      chk("rx buffer", q, {24'h0, last});
    end
    // Mode 3 first; under frame check a bit 7 write must reach only the error flag
    bus(1'b1, ADDR_SERIAL_CONTROL, 8'hd0);
    bus(1'b1, ADDR_MISC_CONTROL, 8'h01);
    bus(1'b1, ADDR_SERIAL_CONTROL, 8'h50);
    FAR.send_frame(8'h3c, 1'b1, 1'b0, 1'b1);
    bus(1'b0, ADDR_SERIAL_CONTROL, 8'h00);
    chk("framing error", q, 32'hd5);
    chk("mode kept", 32'(mode), 32'h3);
    bus(1'b0, ADDR_SERIAL_BUFFER, 8'h00);
    chk("rx buffer", q, 32'h3c);
    for (int j = 0; j < 4; j++) begin
      m = 2'(j);
      bus(1'b1, ADDR_MISC_CONTROL, 8'h00);
      bus(1'b1, ADDR_SERIAL_CONTROL, {m, 6'h08});
      tx_delay <= 4'($random(seed));
      r = 8'($random(seed));
      s0 = n_start;
      bus(1'b1, ADDR_SERIAL_BUFFER, r);
      repeat (24) @(posedge clock_i);
      @(negedge clock_i);
      chk("tx start", n_start - s0, 32'(m != 2'h0));
      chk("tx data", 32'(tx_data), 32'(r));
      chk("tx ninth", 32'(tx_ninth), 32'(m[1]));
      bus(1'b0, ADDR_SERIAL_CONTROL, 8'h00);
      chk("tx flag", q, {24'h0, m, 6'h08 | ((m != 2'h0) ? 6'h02 : 6'h00)});
      for (int e = 0; e < 4; e++) begin
        bus(1'b1, ADDR_MISC_CONTROL, {5'h0, 2'(e), 1'b0});
        @(negedge clock_i);
        chk("irq", 32'(irq), 32'((m != 2'h0) && e == 3));
      end
      // Software clears the flag; hardware held it until now
      bus(1'b1, ADDR_SERIAL_CONTROL, {m, 6'h08});
      @(negedge clock_i);
      chk("cleared", 32'(req), 32'h0);
    end
    conclude();
  end
endmodule : tb_top
`default_nettype wire
